// >>> shared/stc_pkg.sv
// Purpose: shared constants and types of the sweep and trigger controller
// Assumes: 125 MHz system clock, register port with byte addresses
// Notes:   times are held in microseconds unless the name says otherwise
package stc_pkg;

  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned US_PER_S        = 1_000_000;
  localparam int unsigned US_CYC          = CLK_HZ / US_PER_S;

  // ****************************************************************
  // limits
  // ****************************************************************
  localparam int unsigned DELAY_MAX_US    = 100_000_000;
  localparam int unsigned ZS_SWEEP_MIN_US = 1_000;
  localparam int unsigned ZS_SWEEP_MAX_US = 1_000_000_000;
  localparam int unsigned THRESH_MAX      = 100;
  localparam int unsigned THRESH_RST      = 50;
  localparam int unsigned AUTO_DIV        = 1_000;
  localparam int unsigned AUTO_MIN_US     = 1;

  // delay range edges and the resolution step inside each range
  localparam int unsigned DLY_EDGE1 = 1_000;
  localparam int unsigned DLY_EDGE2 = 10_000;
  localparam int unsigned DLY_EDGE3 = 100_000;
  localparam int unsigned DLY_EDGE4 = 1_000_000;
  localparam int unsigned DLY_EDGE5 = 10_000_000;
  localparam int unsigned DLY_STEP0 = 10;
  localparam int unsigned DLY_STEP1 = 100;
  localparam int unsigned DLY_STEP2 = 1_000;
  localparam int unsigned DLY_STEP3 = 10_000;
  localparam int unsigned DLY_STEP4 = 100_000;
  localparam int unsigned DLY_STEP5 = 1_000_000;

  // settle factor per resolution bandwidth index (1,3,10,30,100,300,1000 kHz)
  localparam int unsigned RBW_LAST = 6;
  localparam logic [19:0] RBW_FACTOR [0:6] = '{20'h f4240, 20'h 1b207, 20'h 02710,
                                               20'h 00457, 20'h 00064, 20'h 0000b,
                                               20'h 00001};

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CMD     = 8'h04;
  localparam logic [7:0] REG_SPAN    = 8'h08;
  localparam logic [7:0] REG_RBW     = 8'h0c;
  localparam logic [7:0] REG_MANUAL  = 8'h10;
  localparam logic [7:0] REG_DELAY   = 8'h14;
  localparam logic [7:0] REG_THRESH  = 8'h18;
  localparam logic [7:0] REG_STATUS  = 8'h1c;
  localparam logic [7:0] REG_READOUT = 8'h20;
  localparam logic [7:0] REG_ELAPSED = 8'h24;
  localparam int unsigned CMD_SHOT_BIT = 0;

  typedef enum logic [1:0] {
    SRC_FREE = 2'h0,
    SRC_ENV  = 2'h1,
    SRC_EXT  = 2'h2
  } stc_src_t;

  typedef struct packed {
    logic     falling;
    stc_src_t src;
    logic     manual;
    logic     single;
  } stc_ctrl_t;

  localparam stc_ctrl_t CTRL_RST = '{falling: 1'b0, src: SRC_FREE, manual: 1'b0, single: 1'b0};

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARM   = 2'b01,
    ST_HOLD  = 2'b11,
    ST_SWEEP = 2'b10
  } stc_state_t;

endpackage

// >>> hw/stc_top.sv
// Purpose: sweep sequencer and trigger controller
// Assumes: env_level_i comes from logic on clk_i; outside_trigger_input_i is an asynchronous pin
// Notes:   registers are reached over a plain strobe port, read data one cycle after the strobe
//
// Contract
// - continuous mode, reset default, restarts sweep right after each sweep ends
// - one-shot mode does one pass or capture, then idles
// - free-running source, reset default, starts next sweep at once
// - envelope source starts sweep when envelope rises above threshold
// - envelope source accepted only at zero span, rejected otherwise
// - nonzero span flags envelope source and delay as unavailable
// - outside source starts on rising or falling edge as configured
// - envelope or outside trigger postpones sweep start by holdoff delay
// - holdoff delay accepts zero up to one hundred seconds
// - delay resolution steps 10us,100us,1ms,10ms,100ms,1s per decade
// - threshold is percent of reference, 0 to 100, reset 50
// - new threshold acts immediately
// - zero span sweep time limited to 1 ms .. 1000 s
// - zero span x axis is time from zero to sweep time
// - auto coupling picks shortest settling sweep time for bandwidth and span
// - auto sweep time proportional to span
// - manual sweep time raises uncoupled flag
// - too short sweep time raises level error flag
// - manual time change acts at once; trace refresh at every sweep end
// - auto time x9 for threefold, x100 for tenfold bandwidth drop
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module stc_top
  import stc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic [6:0]  env_level_i,
  input  wire logic        outside_trigger_input_i,
  output logic             sweep_start_o,
  output logic             sweep_active_o,
  output logic             sweep_end_o,
  output logic             holdoff_o,
  output logic      [31:0] sweep_pos_us_o,
  output logic      [31:0] sweep_duration_readout_o,
  output logic             uncoupled_o,
  output logic             level_err_o,
  output logic             env_unavail_o,
  output logic             delay_unavail_o
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  stc_ctrl_t   ctrl_reg,   ctrl_next;
  logic [23:0] span_reg,   span_next;
  logic [2:0]  rbw_reg,    rbw_next;
  logic [31:0] man_reg,    man_next;
  logic [26:0] delay_reg,  delay_next;
  logic [6:0]  thresh_reg, thresh_next;
  logic        shot_req;
  logic        ctrl_wr;
  stc_ctrl_t   wctrl;

  always_comb begin
    ctrl_next   = ctrl_reg;
    span_next   = span_reg;
    rbw_next    = rbw_reg;
    man_next    = man_reg;
    delay_next  = delay_reg;
    thresh_next = thresh_reg;
    wctrl       = stc_ctrl_t'(wdata_i[4:0]);
    ctrl_wr     = wr_i && (addr_i == REG_CTRL);
    shot_req    = wr_i && (addr_i == REG_CMD) && wdata_i[CMD_SHOT_BIT];
    if (ctrl_wr) begin
      ctrl_next.single  = wctrl.single;
      ctrl_next.manual  = wctrl.manual;
      ctrl_next.falling = wctrl.falling;
      // envelope source only at zero span; undefined codes also keep the old source
      if ((wctrl.src == SRC_FREE) || (wctrl.src == SRC_EXT) || ((wctrl.src == SRC_ENV) && (span_reg == '0))) begin
        ctrl_next.src = wctrl.src;
      end
    end
    if (wr_i && (addr_i == REG_SPAN)) begin
      span_next = wdata_i[23:0];
      if ((wdata_i[23:0] != '0) && (ctrl_next.src == SRC_ENV)) begin
        ctrl_next.src = SRC_FREE;
      end
    end
    if (wr_i && (addr_i == REG_RBW)) begin
      rbw_next = (wdata_i > 32'(RBW_LAST)) ? 3'(RBW_LAST) : wdata_i[2:0];
    end
    if (wr_i && (addr_i == REG_MANUAL)) begin
      man_next = wdata_i;
    end
    if (wr_i && (addr_i == REG_DELAY) && (span_reg == '0)) begin
      delay_next = (wdata_i > DELAY_MAX_US) ? 27'(DELAY_MAX_US) : wdata_i[26:0];
    end
    if (wr_i && (addr_i == REG_THRESH)) begin
      thresh_next = (wdata_i > THRESH_MAX) ? 7'(THRESH_MAX) : wdata_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg   <= CTRL_RST;
      span_reg   <= '0;
      rbw_reg    <= '0;
      man_reg    <= 32'(ZS_SWEEP_MIN_US);
      delay_reg  <= '0;
      thresh_reg <= 7'(THRESH_RST);
    end else begin
      ctrl_reg   <= ctrl_next;
      span_reg   <= span_next;
      rbw_reg    <= rbw_next;
      man_reg    <= man_next;
      delay_reg  <= delay_next;
      thresh_reg <= thresh_next;
    end
  end

  // ****************************************************************
  // sweep time coupling
  // ****************************************************************
  logic        zero_span;
  logic [43:0] auto_prod;
  logic [43:0] auto_quo;
  logic [31:0] coupled_sweep_duration;
  logic [31:0] uncoupled_sweep_duration;
  logic [31:0] sweep_us;
  logic        short_sweep;

  always_comb begin
    zero_span                = (span_reg == '0);
    // time grows with span and with the square of the bandwidth drop
    auto_prod                = 44'(span_reg) * 44'(RBW_FACTOR[rbw_reg]);
    auto_quo                 = auto_prod / 44'(AUTO_DIV);
    coupled_sweep_duration   = (auto_quo < 44'(AUTO_MIN_US)) ? 32'(AUTO_MIN_US) : auto_quo[31:0];
    uncoupled_sweep_duration = man_reg;
    if (zero_span) begin
      coupled_sweep_duration = 32'(ZS_SWEEP_MIN_US);
    end
    sweep_us = ctrl_reg.manual ? uncoupled_sweep_duration : coupled_sweep_duration;
    if (zero_span && (sweep_us < ZS_SWEEP_MIN_US)) begin
      sweep_us = 32'(ZS_SWEEP_MIN_US);
    end
    if (zero_span && (sweep_us > ZS_SWEEP_MAX_US)) begin
      sweep_us = 32'(ZS_SWEEP_MAX_US);
    end
    short_sweep = ctrl_reg.manual && !zero_span && (man_reg < coupled_sweep_duration);
  end

  // ****************************************************************
  // holdoff quantisation
  // ****************************************************************
  logic [19:0] step_us;
  logic [26:0] steps_q;

  always_comb begin
    if (delay_reg < 27'(DLY_EDGE1)) begin
      step_us = 20'(DLY_STEP0);
      steps_q = delay_reg / 27'(DLY_STEP0);
    end else if (delay_reg < 27'(DLY_EDGE2)) begin
      step_us = 20'(DLY_STEP1);
      steps_q = delay_reg / 27'(DLY_STEP1);
    end else if (delay_reg < 27'(DLY_EDGE3)) begin
      step_us = 20'(DLY_STEP2);
      steps_q = delay_reg / 27'(DLY_STEP2);
    end else if (delay_reg < 27'(DLY_EDGE4)) begin
      step_us = 20'(DLY_STEP3);
      steps_q = delay_reg / 27'(DLY_STEP3);
    end else if (delay_reg < 27'(DLY_EDGE5)) begin
      step_us = 20'(DLY_STEP4);
      steps_q = delay_reg / 27'(DLY_STEP4);
    end else begin
      step_us = 20'(DLY_STEP5);
      steps_q = delay_reg / 27'(DLY_STEP5);
    end
    if (!zero_span || (ctrl_reg.src == SRC_FREE)) begin
      steps_q = '0;
    end
  end

  // ****************************************************************
  // trigger detection
  // ****************************************************************
  logic       ext_meta_reg, ext_sync_reg, ext_prev_reg;
  logic       env_above_reg;
  logic       env_above;
  logic       ext_edge;
  logic       env_rise;
  logic       trig;
  logic [6:0] pre_reg, pre_next;
  logic       us_tick;

  always_comb begin
    env_above = (env_level_i > thresh_reg);
    env_rise  = env_above && !env_above_reg;
    ext_edge  = ctrl_reg.falling ? (ext_prev_reg && !ext_sync_reg)
                                 : (!ext_prev_reg && ext_sync_reg);
    case (ctrl_reg.src)
      SRC_FREE: trig = 1'b1;
      SRC_ENV:  trig = env_rise && zero_span;
      SRC_EXT:  trig = ext_edge;
      default:  trig = 1'b0;
    endcase
    us_tick  = (pre_reg == 7'(US_CYC - 1));
    pre_next = us_tick ? '0 : pre_reg + 7'h01;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_meta_reg  <= 1'b0;
      ext_sync_reg  <= 1'b0;
      ext_prev_reg  <= 1'b0;
      env_above_reg <= 1'b1;
      pre_reg       <= '0;
    end else begin
      ext_meta_reg  <= outside_trigger_input_i;
      ext_sync_reg  <= ext_meta_reg;
      ext_prev_reg  <= ext_sync_reg;
      env_above_reg <= env_above;
      pre_reg       <= pre_next;
    end
  end

  // ****************************************************************
  // sweep sequencer
  // ****************************************************************
  stc_state_t  state_reg, state_next;
  logic [31:0] elapsed_reg, elapsed_next;
  logic [19:0] sub_reg, sub_next;
  logic [26:0] left_reg, left_next;
  logic        end_now;

  always_comb begin
    state_next   = state_reg;
    elapsed_next = elapsed_reg;
    sub_next     = sub_reg;
    left_next    = left_reg;
    end_now      = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (!ctrl_reg.single || shot_req) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        if (trig) begin
          sub_next     = '0;
          left_next    = steps_q;
          elapsed_next = '0;
          state_next   = (steps_q == '0) ? ST_SWEEP : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (us_tick) begin
          if (sub_reg == step_us - 20'h00001) begin
            sub_next  = '0;
            left_next = left_reg - 27'h0000001;
            if (left_reg == 27'h0000001) begin
              state_next = ST_SWEEP;
            end
          end else begin
            sub_next = sub_reg + 20'h00001;
          end
        end
      end
      ST_SWEEP: begin
        if (us_tick) begin
          elapsed_next = elapsed_reg + 32'h1;
          if (elapsed_next >= sweep_us) begin
            end_now      = 1'b1;
            elapsed_next = '0;
            state_next   = ctrl_reg.single ? ST_IDLE : ST_ARM;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg   <= ST_IDLE;
      elapsed_reg <= '0;
      sub_reg     <= '0;
      left_reg    <= '0;
    end else begin
      state_reg   <= state_next;
      elapsed_reg <= elapsed_next;
      sub_reg     <= sub_next;
      left_reg    <= left_next;
    end
  end

  // ****************************************************************
  // outputs and register read back
  // ****************************************************************
  logic [31:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    if (rd_i) begin
      case (addr_i)
        REG_CTRL:    rdata_next = 32'(ctrl_reg);
        REG_SPAN:    rdata_next = 32'(span_reg);
        REG_RBW:     rdata_next = 32'(rbw_reg);
        REG_MANUAL:  rdata_next = man_reg;
        REG_DELAY:   rdata_next = 32'(delay_reg);
        REG_THRESH:  rdata_next = 32'(thresh_reg);
        REG_STATUS:  rdata_next = {26'h0, !zero_span, short_sweep, ctrl_reg.manual, 1'b0, state_reg};
        REG_READOUT: rdata_next = sweep_us;
        REG_ELAPSED: rdata_next = elapsed_reg;
        default:     rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o                  <= '0;
      sweep_start_o            <= 1'b0;
      sweep_active_o           <= 1'b0;
      sweep_end_o              <= 1'b0;
      holdoff_o                <= 1'b0;
      sweep_pos_us_o           <= '0;
      sweep_duration_readout_o <= 32'(ZS_SWEEP_MIN_US);
      uncoupled_o              <= 1'b0;
      level_err_o              <= 1'b0;
      env_unavail_o            <= 1'b0;
      delay_unavail_o          <= 1'b0;
    end else begin
      rdata_o                  <= rdata_next;
      sweep_start_o            <= (state_next == ST_SWEEP) && (state_reg != ST_SWEEP);
      sweep_active_o           <= (state_next == ST_SWEEP);
      sweep_end_o              <= end_now;
      holdoff_o                <= (state_next == ST_HOLD);
      sweep_pos_us_o           <= elapsed_next;
      sweep_duration_readout_o <= sweep_us;
      uncoupled_o              <= ctrl_reg.manual;
      level_err_o              <= short_sweep;
      env_unavail_o            <= !zero_span;
      delay_unavail_o          <= !zero_span;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_cont_restart;
    @(posedge clk_i) disable iff (sys_rst_i) (end_now && !ctrl_reg.single) |=> (state_reg == ST_ARM);
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("continuous sweep did not rearm");

  property p_single_idle;
    @(posedge clk_i) disable iff (sys_rst_i) (end_now && ctrl_reg.single) |=> (state_reg == ST_IDLE) ##1 sweep_end_o == 1'b0;
  endproperty
  a_single_idle: assert property (p_single_idle) else $error("one-shot did not idle after pass");

  property p_no_self_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == ST_IDLE && ctrl_reg.single && !shot_req && !ctrl_wr) |=> (state_reg == ST_IDLE);
  endproperty
  a_no_self_start: assert property (p_no_self_start) else $error("one-shot started without command");

  property p_free_start;
    @(posedge clk_i) disable iff (sys_rst_i) (state_reg == ST_ARM && ctrl_reg.src == SRC_FREE) |=> sweep_active_o;
  endproperty
  a_free_start: assert property (p_free_start) else $error("free run did not start at once");

  property p_env_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == ST_ARM && ctrl_reg.src == SRC_ENV && env_rise && steps_q == '0) |=> sweep_start_o;
  endproperty
  a_env_start: assert property (p_env_start) else $error("envelope rise did not start sweep");

  property p_env_reject;
    @(posedge clk_i) disable iff (sys_rst_i) (span_reg != '0) |-> (ctrl_reg.src != SRC_ENV);
  endproperty
  a_env_reject: assert property (p_env_reject) else $error("envelope source held at nonzero span");

  property p_unavail;
    @(posedge clk_i) disable iff (sys_rst_i) (span_reg != '0) |=> (env_unavail_o && delay_unavail_o);
  endproperty
  a_unavail: assert property (p_unavail) else $error("unavailable flags missing at nonzero span");

  property p_edge_start;
    @(posedge clk_i) disable iff (sys_rst_i)
      (state_reg == ST_ARM && ctrl_reg.src == SRC_EXT && ext_edge && steps_q == '0) |=> sweep_start_o;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("outside edge did not start sweep");

  property p_holdoff;
    @(posedge clk_i) disable iff (sys_rst_i) (state_reg == ST_ARM && trig && steps_q != '0) |=> holdoff_o && !sweep_active_o;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("trigger did not enter holdoff");

  property p_delay_max;
    @(posedge clk_i) disable iff (sys_rst_i) delay_reg <= 27'(DELAY_MAX_US);
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("delay above limit");

  property p_zs_limit;
    @(posedge clk_i) disable iff (sys_rst_i)
      zero_span |-> (sweep_us >= ZS_SWEEP_MIN_US && sweep_us <= ZS_SWEEP_MAX_US);
  endproperty
  a_zs_limit: assert property (p_zs_limit) else $error("zero span sweep time out of range");

  property p_uncoupled;
    @(posedge clk_i) disable iff (sys_rst_i) $rose(ctrl_reg.manual) |=> uncoupled_o;
  endproperty
  a_uncoupled: assert property (p_uncoupled) else $error("uncoupled flag missing");

endmodule

// >>> verification/stc_fe.sv
// Purpose: front end model, envelope level and outside trigger pin
// Assumes: envelope level follows clk_i
// Notes:   the pin moves away from clock edges, like a real async source
`timescale 1ns/1ps
module stc_fe (
  input  wire logic       clk_i,
  input  wire logic [6:0] env_set_i,
  output logic      [6:0] env_level_o,
  output logic            pin_o
);
  initial begin
    pin_o = 1'b0;
  end
  always @(posedge clk_i) env_level_o <= env_set_i;
  task automatic flip();
    #3 pin_o = ~pin_o;
  endtask
endmodule

// >>> verification/testbench.sv
// Purpose: self-checking bench of the sweep and trigger controller
// Assumes: 8 ns clock, plain strobe register port
// Notes:   long zero-span sweeps are cut short by a nonzero span
`timescale 1ns/1ps
module testbench;
  import stc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr  = 1'b0;
  logic        rd  = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, pos, rdo, v;
  logic [6:0]  env_set = 7'h00;
  logic [6:0]  env;
  logic        pin, st, act, en, ho, unc, lerr, eun, dun;
  int          n_errors = 0;
  int          compares = 0;
  int          n;
  stc_fe i_fe (.clk_i(clk), .env_set_i(env_set), .env_level_o(env), .pin_o(pin));
  stc_top i_dut (.clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .env_level_i(env), .outside_trigger_input_i(pin), .sweep_start_o(st),
    .sweep_active_o(act), .sweep_end_o(en), .holdoff_o(ho), .sweep_pos_us_o(pos),
    .sweep_duration_readout_o(rdo), .uncoupled_o(unc), .level_err_o(lerr),
    .env_unavail_o(eun), .delay_unavail_o(dun));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // counts cycles until a start or end pulse, capped at lim
  task automatic wait_ev(logic is_end, int lim);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while ((is_end ? en : st) !== 1'b1 && n < lim);
  endtask
  // ends any sweep at a short nonzero span, leaves single mode idle at zero span
  task automatic go_idle();
    wr_reg(REG_SPAN, 32'd5000);
    wr_reg(REG_CTRL, 32'h1);
    wait_ev(1'b1, 1000);
    wr_reg(REG_SPAN, 32'h0);
  endtask
  task automatic t_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (9) @(posedge clk);
    rst <= 1'b0;
    wait_ev(1'b0, 4);
    chk("first start", 1, n <= 3);
    chk("readout", 32'd1000, rdo);
    chk("uncoupled", 0, unc);
    rd_reg(REG_THRESH);
    chk("thresh", 32'd50, v);
    $display("reset test done");
  endtask
  task automatic t_couple();
    int tb [5][3] = '{'{6, 5000, 5}, '{6, 10000, 10}, '{5, 1000, 11}, '{4, 1000, 100}, '{2, 3, 30}};
    foreach (tb[i]) begin
      wr_reg(REG_RBW, tb[i][0]);
      wr_reg(REG_SPAN, tb[i][1]);
      rd_reg(REG_READOUT);
      chk("coupled time", tb[i][2], v);
    end
    chk("env unavail", 1, eun);
    chk("delay unavail", 1, dun);
    wr_reg(REG_CTRL, 32'h4);
    rd_reg(REG_CTRL);
    chk("env refused", 0, v);
    wr_reg(REG_DELAY, 32'd50);
    rd_reg(REG_DELAY);
    chk("delay refused", 0, v);
    rd_reg(8'h30);
    chk("unmapped", 0, v);
    wr_reg(REG_RBW, 32'd6);
    wr_reg(REG_SPAN, 32'd5000);
    $display("coupling test done");
  endtask
  task automatic t_cont();
    wait_ev(1'b1, 1000);
    wait_ev(1'b0, 5);
    chk("restart", 1, n <= 3);
    chk("active", 1, act);
    chk("pos at start", 1, pos <= 1);
    wait_ev(1'b1, 700);
    chk("sweep length", 1, n >= 500 && n <= 640);
    wr_reg(REG_CTRL, 32'h2);
    wr_reg(REG_MANUAL, 32'd3);
    @(posedge clk);
    #1 chk("uncoupled", 1, unc);
    chk("level err", 1, lerr);
    chk("manual time", 3, rdo);
    wr_reg(REG_MANUAL, 32'd8);
    @(posedge clk);
    #1 chk("level ok", 0, lerr);
    chk("manual time", 8, rdo);
    wr_reg(REG_CTRL, 32'h0);
    $display("continuous test done");
  endtask
  task automatic t_single();
    wr_reg(REG_CTRL, 32'h1);
    wait_ev(1'b1, 1000);
    wait_ev(1'b0, 1500);
    chk("idle", 1500, n);
    rd_reg(REG_STATUS);
    chk("status idle", 32'h20, v);
    wr_reg(REG_CMD, 32'h1);
    wait_ev(1'b0, 8);
    chk("shot start", 1, n < 8);
    wait_ev(1'b1, 800);
    wait_ev(1'b0, 1000);
    chk("one pass", 1000, n);
    wr_reg(REG_SPAN, 32'h0);
    wr_reg(REG_CTRL, 32'h3);
    wr_reg(REG_MANUAL, 32'd5);
    rd_reg(REG_READOUT);
    chk("zs min", 32'd1000, v);
    wr_reg(REG_MANUAL, 32'h77359400);
    rd_reg(REG_READOUT);
    chk("zs max", 32'h3b9aca00, v);
    wr_reg(REG_DELAY, 32'hbebc2000);
    rd_reg(REG_DELAY);
    chk("delay max", 32'h05f5e100, v);
    wr_reg(REG_THRESH, 32'd200);
    rd_reg(REG_THRESH);
    chk("thresh max", 32'd100, v);
    $display("single test done");
  endtask
  task automatic t_trig();
    go_idle();
    wr_reg(REG_DELAY, 32'h0);
    wr_reg(REG_THRESH, 32'd60);
    env_set <= 7'd55;
    wr_reg(REG_CTRL, 32'h5);
    wr_reg(REG_CMD, 32'h1);
    wait_ev(1'b0, 50);
    chk("below thresh", 50, n);
    wr_reg(REG_THRESH, 32'd50);
    wait_ev(1'b0, 8);
    chk("env start", 1, n < 8);
    go_idle();
    wr_reg(REG_DELAY, 32'd35);
    wr_reg(REG_CTRL, 32'h9);
    wr_reg(REG_CMD, 32'h1);
    i_fe.flip();
    repeat (100) @(posedge clk);
    #1 chk("holdoff", 1, ho);
    chk("held inactive", 0, act);
    wait_ev(1'b0, 4000);
    chk("delayed start", 1, n >= 3500 && n <= 3670);
    go_idle();
    wr_reg(REG_DELAY, 32'h0);
    wr_reg(REG_CTRL, 32'h19);
    wr_reg(REG_CMD, 32'h1);
    i_fe.flip();
    wait_ev(1'b0, 10);
    chk("falling start", 1, n <= 8);
    $display("trigger test done");
  endtask
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #(8 * 60000);
    n_errors++;
    end_sim();
  end
  initial begin
    t_reset();
    t_couple();
    t_cont();
    t_single();
    t_trig();
    end_sim();
  end
endmodule
